/* hdl/tape_bit_serial_rw.sv */
// Tape bit-serial read/write logic with an APB3 register slave.
// Assumes read pulse pins are asynchronous; all other inputs are synchronous to pclk.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

module tape_bit_serial_rw #(
  parameter int GAP_CYC = tape_rw_pkg::GAP_CYC,
  parameter int DELAY_CYC = tape_rw_pkg::DELAY_CYC,
  parameter int SEARCH_CYC = tape_rw_pkg::SEARCH_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive side inputs
  input wire logic tape_base_clock,
  input wire logic read_ones_pulse,
  input wire logic read_zeros_pulse,
  input wire logic write_protect_switch,
  input wire logic restart_hold_n,
  // Drive side outputs
  output logic write_shift_clock,
  output logic write_shift_clock_tp,
  output logic write_serial_data,
  output logic ones_track_head,
  output logic zeros_track_head,
  output logic write_current_en,
  output logic write_mode_n,
  output logic copy_inhibit,
  output logic read_bit_clock,
  output logic read_bit_value
);

  localparam tape_rw_pkg::state_t RESET_STATE = '{
    mode_n: 1'b1, bip: 1'b1, wst: tape_rw_pkg::W_IDLE, default: '0};

  tape_rw_pkg::state_t s_reg;
  tape_rw_pkg::state_t s_next;

  logic access;
  logic done;
  logic wr_done;
  logic load;
  logic trig;
  logic srch_clr;
  logic base_rise;
  logic wclk_rise;
  logic edge_one;
  logic edge_zero;
  logic rd_en;
  logic bit_take;
  logic bit_in;
  logic [7:0] rsh_new;
  logic gap_exp;
  logic srch_exp;
  logic dly_exp;
  logic [31:0] rd_word;
  logic hit;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign write_shift_clock = s_reg.wclk;
  assign write_shift_clock_tp = s_reg.wclk_tp;
  assign write_serial_data = s_reg.wser;
  assign ones_track_head = s_reg.ones;
  assign zeros_track_head = s_reg.zeros;
  assign write_current_en = s_reg.wcur;
  assign write_mode_n = s_reg.mode_n;
  assign copy_inhibit = s_reg.copy;
  assign read_bit_clock = s_reg.rclk;
  assign read_bit_value = s_reg.rval;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign access = psel && penable && !s_reg.pready;
  assign done = psel && penable && s_reg.pready;
  assign wr_done = done && pwrite && !s_reg.pslverr;
  assign trig = wr_done && (paddr == tape_rw_pkg::STROBE_OFF) && pwdata[tape_rw_pkg::STB_TRIG];
  assign srch_clr = wr_done && (paddr == tape_rw_pkg::STROBE_OFF) && pwdata[tape_rw_pkg::STB_SRCH];
  assign load = wr_done && (paddr == tape_rw_pkg::WDATA_OFF) && (s_reg.wst == tape_rw_pkg::W_IDLE)
    && !(s_reg.drun && s_reg.gsel);

  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      tape_rw_pkg::CTRL_OFF: begin
        rd_word[3:0] = {s_reg.motion, s_reg.copy, s_reg.gsel, ~s_reg.mode_n};
      end
      tape_rw_pkg::WDATA_OFF: begin
        rd_word[7:0] = s_reg.wlast;
      end
      tape_rw_pkg::STROBE_OFF: begin
        rd_word = 32'h0000_0000;
      end
      tape_rw_pkg::STATUS_OFF: begin
        rd_word[8:0] = {s_reg.drun, (s_reg.wst == tape_rw_pkg::W_SHIFT), s_reg.gap_seen, s_reg.dexp,
          s_reg.fgf, s_reg.data_begin, s_reg.file_mark, s_reg.rec_mark, s_reg.bip};
      end
      tape_rw_pkg::RDATA_OFF: begin
        rd_word[7:0] = s_reg.rbyte;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Event terms
  // ---------------------------------------------------------------
  assign base_rise = tape_base_clock && !s_reg.base_prev;
  assign wclk_rise = base_rise && (s_reg.div_cnt == 8'(tape_rw_pkg::WCLK_DIV - 1)) && !s_reg.wclk;
  assign edge_one = s_reg.s_one[1] && !s_reg.s_one[2];
  assign edge_zero = s_reg.s_zero[1] && !s_reg.s_zero[2];
  assign rd_en = s_reg.mode_n && s_reg.motion;
  assign bit_take = rd_en && !s_reg.rclk && (edge_one || edge_zero);
  assign bit_in = edge_one;
  assign rsh_new = {s_reg.rsh[6:0], bit_in};
  assign gap_exp = rd_en && !bit_take && (s_reg.gcnt == tape_rw_pkg::GAP_W'(GAP_CYC - 1));
  assign srch_exp = s_reg.bip && (s_reg.scnt == tape_rw_pkg::SEARCH_W'(SEARCH_CYC - 2));
  assign dly_exp = s_reg.drun && (s_reg.dcnt == tape_rw_pkg::GAP_W'(DELAY_CYC - 1));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // APB: one wait state, then completion
    if (access) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !hit || (pwrite && (paddr == tape_rw_pkg::STATUS_OFF || paddr == tape_rw_pkg::RDATA_OFF));
      s_next.prdata = (pwrite || !hit) ? 32'h0000_0000 : rd_word;
    end else if (done) begin
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
    end
    if (wr_done && paddr == tape_rw_pkg::CTRL_OFF) begin
      s_next.mode_n = !pwdata[tape_rw_pkg::CTRL_MODE];
      s_next.gsel = pwdata[tape_rw_pkg::CTRL_GSEL];
      s_next.copy = pwdata[tape_rw_pkg::CTRL_COPY];
      s_next.motion = pwdata[tape_rw_pkg::CTRL_MOTION];
    end

    // Write clock divided from base clock
    s_next.base_prev = tape_base_clock;
    if (base_rise) begin
      if (s_reg.div_cnt == 8'(tape_rw_pkg::WCLK_DIV - 1)) begin
        s_next.div_cnt = 8'h00;
        s_next.wclk = !s_reg.wclk;
        s_next.wclk_tp = !s_reg.wclk;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 8'h01;
      end
    end

    // Write current gating
    s_next.wcur = !s_reg.mode_n && write_protect_switch && restart_hold_n;

    // Write serialiser
    case (s_reg.wst)
      tape_rw_pkg::W_IDLE: begin
        if (load) begin
          s_next.wlast = pwdata[7:0];
          s_next.wsh = pwdata[7:0];
          s_next.wbits = 4'(tape_rw_pkg::BYTE_BITS);
          s_next.wst = tape_rw_pkg::W_SHIFT;
        end
      end
      tape_rw_pkg::W_SHIFT: begin
        if (wclk_rise) begin
          s_next.wser = s_reg.wsh[7];
          s_next.wsh = {s_reg.wsh[6:0], 1'b0};
          s_next.wbits = s_reg.wbits - 4'h1;
          if (s_reg.wcur && s_reg.wsh[7]) begin
            s_next.ones = !s_reg.ones;
          end else if (s_reg.wcur) begin
            s_next.zeros = !s_reg.zeros;
          end
          if (s_reg.wbits == 4'h1) begin
            s_next.wst = tape_rw_pkg::W_IDLE;
          end
        end
      end
      default: begin
        s_next.wst = tape_rw_pkg::W_IDLE;
      end
    endcase

    // Read pulse synchronisers
    s_next.s_one = {s_reg.s_one[1:0], read_ones_pulse};
    s_next.s_zero = {s_reg.s_zero[1:0], read_zeros_pulse};

    // Read bit pulse, 1 us long
    if (bit_take) begin
      s_next.rclk = 1'b1;
      s_next.rval = bit_in;
      s_next.pcnt = tape_rw_pkg::PULSE_W'(tape_rw_pkg::PULSE_CYC - 1);
    end else if (s_reg.rclk) begin
      if (s_reg.pcnt == '0) begin
        s_next.rclk = 1'b0;
      end else begin
        s_next.pcnt = s_reg.pcnt - 1'b1;
      end
    end
    if (!rd_en) begin
      s_next.rclk = 1'b0;
    end

    // Deserialiser and bit counter
    if (bit_take) begin
      s_next.rsh = rsh_new;
      s_next.gcnt = '0;
      s_next.rec_mark = 1'b0;
      s_next.file_mark = 1'b0;
      s_next.gap_seen = 1'b0;
      s_next.data_begin = s_reg.gap_seen || s_reg.data_begin;
      if (s_reg.rbits == 4'(tape_rw_pkg::BYTE_BITS - 1)) begin
        s_next.rbyte = rsh_new;
        s_next.rbits = 4'h0;
        s_next.bip = 1'b1;
        s_next.intercharacter_gap = 4'h0;
      end else begin
        s_next.rbits = s_reg.rbits + 4'h1;
        s_next.bip = 1'b0;
      end
    end else if (!rd_en) begin
      s_next.gcnt = '0;
    end else if (gap_exp) begin
      s_next.gcnt = '0;
      s_next.gap_seen = 1'b1;
      s_next.data_begin = 1'b0;
      s_next.rbits = 4'h0;
      s_next.bip = 1'b1;
      if (s_reg.intercharacter_gap != 4'(tape_rw_pkg::FILE_GAPS)) begin
        s_next.intercharacter_gap = s_reg.intercharacter_gap + 4'h1;
      end
      if (s_reg.intercharacter_gap == 4'(tape_rw_pkg::RECORD_GAPS - 1)) begin
        s_next.rec_mark = 1'b1;
      end
      if (s_reg.intercharacter_gap == 4'(tape_rw_pkg::FILE_GAPS - 1)) begin
        s_next.file_mark = 1'b1;
      end
    end else begin
      s_next.gcnt = s_reg.gcnt + 1'b1;
    end

    // File gap search timer, set wins over clear
    if (srch_clr || !s_reg.bip) begin
      s_next.scnt = '0;
    end else if (s_reg.scnt != tape_rw_pkg::SEARCH_W'(SEARCH_CYC - 1)) begin
      s_next.scnt = s_reg.scnt + 1'b1;
    end
    if (srch_exp) begin
      s_next.fgf = 1'b1;
    end else if (srch_clr) begin
      s_next.fgf = 1'b0;
    end

    // Gap trigger delay, a restart wins over expiry but the expiry flag still sets
    if (trig) begin
      s_next.dcnt = '0;
      s_next.drun = 1'b1;
    end else if (dly_exp) begin
      s_next.drun = 1'b0;
    end else if (s_reg.drun) begin
      s_next.dcnt = s_reg.dcnt + 1'b1;
    end
    if (dly_exp) begin
      s_next.dexp = 1'b1;
    end else if (trig) begin
      s_next.dexp = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // tape_bit_serial_rw

/* hdl/tape_rw_pkg.sv */
// Constants, register map and state types for the tape bit-serial read/write block.
// Assumes a 125 MHz APB clock and drive-side pins that are already at logic levels.
// How it works
// - A data-register write captures one byte, then sends its 8 bits serially.
// - Write shift clock is divided from tape base clock, with a test-point copy.
// - Shift register latches on the load strobe, then shifts eight times on clock rises.
// - Each read bit pulse shifts one bit in; the byte is read as 8 parallel bits.
// - Gap timer, restarted by read bits, expires after 40 us of silence.
// - Byte-in-progress is low while a byte is read, high once it is loaded.
// - Four consecutive gaps flag record end, eight flag file end; data start is flagged.
// - 32 ms search timer, cleared by strobe, restarted by byte activity, flags file gap.
// - Gap trigger starts a 40 us delay that reports expiry, usable as a timer.
// - Write current only in write mode; read pulses suppressed in write mode.
// - A written one toggles the ones-track flop, a zero the zeros-track flop.
// - Write current is blocked while the write protect switch is low.
// - Write current is blocked while restart hold is low.
// - Copy inhibit follows the control register copy bit; firmware parks the beam first.
// - Each flux reversal yields a 1 us read pulse; a flop records which track.

package tape_rw_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int GAP_US = 40;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int DELAY_US = 40;
  localparam int DELAY_CYC = DELAY_US * CLK_MHZ;
  localparam int SEARCH_MS = 32;
  localparam int SEARCH_CYC = SEARCH_MS * 1000 * CLK_MHZ;
  localparam int PULSE_US = 1;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int GAP_W = 13;
  localparam int SEARCH_W = 22;
  localparam int PULSE_W = 7;
  localparam int WCLK_DIV = 1;
  localparam int BYTE_BITS = 8;
  localparam int RECORD_GAPS = 4;
  localparam int FILE_GAPS = 8;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] WDATA_OFF = 12'h004;
  localparam logic [11:0] STROBE_OFF = 12'h008;
  localparam logic [11:0] STATUS_OFF = 12'h00C;
  localparam logic [11:0] RDATA_OFF = 12'h010;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_GSEL = 1;
  localparam int CTRL_COPY = 2;
  localparam int CTRL_MOTION = 3;
  localparam int STB_TRIG = 0;
  localparam int STB_SRCH = 1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {W_IDLE, W_SHIFT} wr_state_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic mode_n;
    logic gsel;
    logic copy;
    logic motion;
    logic base_prev;
    logic [7:0] div_cnt;
    logic wclk;
    logic wclk_tp;
    wr_state_t wst;
    logic [7:0] wlast;
    logic [7:0] wsh;
    logic [3:0] wbits;
    logic wser;
    logic ones;
    logic zeros;
    logic wcur;
    logic [2:0] s_one;
    logic [2:0] s_zero;
    logic [PULSE_W-1:0] pcnt;
    logic rclk;
    logic rval;
    logic [7:0] rsh;
    logic [3:0] rbits;
    logic [7:0] rbyte;
    logic bip;
    logic [GAP_W-1:0] gcnt;
    logic gap_seen;
    logic [3:0] intercharacter_gap;
    logic rec_mark;
    logic file_mark;
    logic data_begin;
    logic [SEARCH_W-1:0] scnt;
    logic fgf;
    logic [GAP_W-1:0] dcnt;
    logic drun;
    logic dexp;
  } state_t;

endpackage

/* bench/tape_rw_chk.sv */
// Checker for the tape read/write block, bound to its top module.
// Assumes pclk is the only clock and presetn an async active-low reset.
`timescale 1ns/10ps

module tape_rw_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Drive side
  input wire logic write_protect_switch,
  input wire logic restart_hold_n,
  input wire logic write_shift_clock,
  input wire logic write_shift_clock_tp,
  input wire logic write_serial_data,
  input wire logic ones_track_head,
  input wire logic zeros_track_head,
  input wire logic write_current_en,
  input wire logic write_mode_n,
  input wire logic read_bit_clock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hi_cnt;

  // Length of the current read pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= read_bit_clock ? hi_cnt + 8'h01 : 8'h00;
  end

  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("answer not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  wcur_block_a: assert property (!write_protect_switch || !restart_hold_n |=> !write_current_en)
    else $error("write current while blocked");
  wcur_mode_a: assert property (write_current_en |-> !write_mode_n || !$past(write_mode_n))
    else $error("write current outside write mode");
  tp_copy_a: assert property (write_shift_clock_tp == write_shift_clock)
    else $error("test point differs from shift clock");
  ones_toggle_a: assert property ($changed(ones_track_head) |-> $rose(write_shift_clock) && write_serial_data)
    else $error("ones track toggled without a written one");
  zeros_toggle_a: assert property ($changed(zeros_track_head) |-> $rose(write_shift_clock) && !write_serial_data)
    else $error("zeros track toggled without a written zero");
  read_quiet_a: assert property (!write_mode_n |-> !$rose(read_bit_clock))
    else $error("read pulse in write mode");
  rclk_width_a: assert property ($fell(read_bit_clock) |-> hi_cnt == tape_rw_pkg::PULSE_CYC)
    else $error("read pulse width wrong");

  cover property ($rose(read_bit_clock));
  cover property (pready && pslverr);
  cover property ($changed(ones_track_head));
endmodule // tape_rw_chk

bind tape_bit_serial_rw tape_rw_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .write_protect_switch(write_protect_switch), .restart_hold_n(restart_hold_n),
  .write_shift_clock(write_shift_clock), .write_shift_clock_tp(write_shift_clock_tp),
  .write_serial_data(write_serial_data), .ones_track_head(ones_track_head), .zeros_track_head(zeros_track_head),
  .write_current_en(write_current_en), .write_mode_n(write_mode_n), .read_bit_clock(read_bit_clock)
);

/* bench/tape_drive_model.sv */
// Drive-side model: flux pulses on the ones and zeros read lines.
// Assumes the caller waits for each task call to return.
`timescale 1ns/10ps

module tape_drive_model (
  // Clock
  input wire logic pclk,
  // Read pulses
  output logic ones_o,
  output logic zeros_o
);
  initial begin
    ones_o = 1'b0;
    zeros_o = 1'b0;
  end

  // Sends n bits MSB first, one flux pulse each
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (150) @(posedge pclk);
      ones_o <= b[7-i];
      zeros_o <= !b[7-i];
      repeat (4) @(posedge pclk);
      ones_o <= 1'b0;
      zeros_o <= 1'b0;
    end
  endtask
endmodule // tape_drive_model

/* bench/tape_bit_serial_rw_test.sv */
// Self-checking bench for the tape read/write block.
// Assumes the drive model and the bound checker are compiled alongside.
`timescale 1ns/10ps

module tape_bit_serial_rw_test;
  localparam int GAP = 300;
  localparam int DLY = 40;
  localparam int SRCH = 1000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, prev;
  logic tape_base_clock, ones_p, zeros_p, protect, hold_n;
  logic wclk, wclk_tp, wser, ones_h, zeros_h, wcur, wmode_n, copy_inh, rclk, rval;
  logic wclk_prev, ones_prev, zeros_prev, armed;
  logic [2:0] bdiv;
  logic [7:0] b;
  logic [31:0] seed;
  logic [31:0] exp_bits[$];
  int bad_count, num_checks, n1, n0, nbits, pop;

  tape_bit_serial_rw #(.GAP_CYC(GAP), .DELAY_CYC(DLY), .SEARCH_CYC(SRCH)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tape_base_clock(tape_base_clock),
    .read_ones_pulse(ones_p), .read_zeros_pulse(zeros_p), .write_protect_switch(protect),
    .restart_hold_n(hold_n), .write_shift_clock(wclk), .write_shift_clock_tp(wclk_tp),
    .write_serial_data(wser), .ones_track_head(ones_h), .zeros_track_head(zeros_h),
    .write_current_en(wcur), .write_mode_n(wmode_n), .copy_inhibit(copy_inh),
    .read_bit_clock(rclk), .read_bit_value(rval));

  tape_drive_model drv (.pclk(pclk), .ones_o(ones_p), .zeros_o(zeros_p));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic status(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, tape_rw_pkg::STATUS_OFF, 32'h0);
    check(rd & mask, exp);
  endtask

  // One byte out with given protect and hold levels
  task automatic wr_byte(input logic p, input logic h);
    b = rnd();
    protect <= p;
    hold_n <= h;
    pop = 0;
    exp_bits.delete();
    for (int i = 7; i >= 0; i--) begin
      exp_bits.push_back({31'h0, b[i]});
      pop += int'(b[i]);
    end
    n1 = 0;
    n0 = 0;
    nbits = 0;
    apb(1'b1, tape_rw_pkg::WDATA_OFF, {24'h0, b});
    // Free-running shift clock: only rises launched after the load count
    @(posedge pclk);
    armed <= 1'b1;
    do apb(1'b0, tape_rw_pkg::STATUS_OFF, 32'h0); while (rd[7] !== 1'b0);
    repeat (4) @(posedge pclk);
    check(32'(nbits), 32'h8);
    check(32'(n1), (p && h) ? 32'(pop) : 32'h0);
    check(32'(n0), (p && h) ? 32'(8 - pop) : 32'h0);
    armed <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clocks and monitor
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    bdiv <= bdiv + 3'h1;
    tape_base_clock <= bdiv[2];
    if (armed && exp_bits.size() > 0 && wclk && !wclk_prev) begin
      nbits++;
      check({31'h0, wser}, exp_bits.pop_front());
    end
    n1 += int'(ones_h !== ones_prev);
    n0 += int'(zeros_h !== zeros_prev);
    wclk_prev = wclk;
    ones_prev = ones_h;
    zeros_prev = zeros_h;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tape_base_clock, bdiv} = '0;
    {wclk_prev, ones_prev, zeros_prev, armed, presetn} = '0;
    protect = 1'b1;
    hold_n = 1'b1;
    seed = 32'h7428;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    status(32'hFFFFFFFF, 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, tape_rw_pkg::STATUS_OFF, 32'hFF);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, tape_rw_pkg::CTRL_OFF, 32'(i));
      apb(1'b0, tape_rw_pkg::CTRL_OFF, 32'h0);
      check(rd, 32'(i));
      check({31'h0, wmode_n}, {31'h0, !i[0]});
      check({31'h0, copy_inh}, {31'h0, i[2]});
    end
    apb(1'b1, tape_rw_pkg::CTRL_OFF, 32'h1);
    wr_byte(1'b1, 1'b1);
    wr_byte(1'b0, 1'b1);
    wr_byte(1'b1, 1'b0);
    protect <= 1'b1;
    hold_n <= 1'b1;
    apb(1'b1, tape_rw_pkg::CTRL_OFF, 32'h8);
    drv.send(rnd(), 3);
    status(32'h1, 32'h0);
    repeat (GAP * 4 + 150) @(posedge pclk);
    apb(1'b1, tape_rw_pkg::STROBE_OFF, 32'h2);
    b = rnd();
    drv.send(b, 8);
    apb(1'b0, tape_rw_pkg::RDATA_OFF, 32'h0);
    check(rd, {24'h0, b});
    check({31'h0, rval}, {31'h0, b[0]});
    prev = rd;
    status(32'h1F, 32'h09);
    repeat (GAP * 4 + 150) @(posedge pclk);
    status(32'h1F, 32'h13);
    repeat (GAP * 4) @(posedge pclk);
    status(32'h1F, 32'h17);
    apb(1'b1, tape_rw_pkg::STROBE_OFF, 32'h2);
    status(32'h10, 32'h0);
    repeat (SRCH + 100) @(posedge pclk);
    status(32'h10, 32'h10);
    apb(1'b1, tape_rw_pkg::CTRL_OFF, 32'hA);
    apb(1'b1, tape_rw_pkg::STROBE_OFF, 32'h1);
    status(32'h20, 32'h0);
    // Byte load refused while the gap delay runs with gap select set
    apb(1'b1, tape_rw_pkg::WDATA_OFF, {24'h0, ~b});
    status(32'h80, 32'h0);
    repeat (DLY + 20) @(posedge pclk);
    status(32'h20, 32'h20);
    repeat (272 * DLY / 40) @(posedge pclk);
    apb(1'b1, tape_rw_pkg::CTRL_OFF, 32'h9);
    drv.send(~b, 8);
    apb(1'b0, tape_rw_pkg::RDATA_OFF, 32'h0);
    check(rd, prev);
    check({31'h0, rval}, {31'h0, b[0]});
    // Normalizing gap, then erase: current on, no flux reversals
    n1 = 0;
    n0 = 0;
    repeat (90 * DLY / 40) @(posedge pclk);
    repeat (300 * SRCH / 32) @(posedge pclk);
    check({31'h0, wcur}, 32'h1);
    check(32'(n1 + n0), 32'h0);
    stop_test();
  end
endmodule // tape_bit_serial_rw_test
